// ### hbp_pkg.sv
// hbp_pkg: shared constants and types of the host bus port and its straps
package hbp_pkg;

	// ==========================================================
	// pin widths and register count
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int STYLE_W = 3;
	localparam int NREGS = 128;

	// ==========================================================
	// host bus styles selected by the host type strap
	typedef enum logic [STYLE_W-1:0] {
		STYLE_MUX = 3'h1,
		STYLE_SEP = 3'h2,
		STYLE_DIR = 3'h3,
		STYLE_SERIAL = 3'h4,
		STYLE_EPROM = 3'h5
	} hbp_style_t;

	// ==========================================================
	// device registers seeded from straps
	localparam logic [ADDR_W-1:0] REG_OPMODE = 7'h34;
	localparam logic [ADDR_W-1:0] REG_RATE = 7'h38;
	localparam int OPMODE_PB_BIT = 1;
	localparam int OPMODE_NET_BIT = 2;
	localparam int RATE_NET_LO_BIT = 5;
	localparam int RATE_NET_HI_BIT = 6;
	localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

	// ==========================================================
	// serial frame: one direction bit, 7 address bits, 8 data bits
	localparam int SER_CMD_BITS = 8;
	localparam int SER_FRAME_BITS = 16;
	localparam int SER_CNT_W = 5;

	// ==========================================================
	// timing counts, in aclk cycles
	localparam int EPROM_WAIT_CYC = 12;
	localparam int HOST_HOLD_CYC = 4;
	localparam int SCLK_HALF_CYC = 8;

	// ==========================================================
	// controller registers on the AXI4-Lite side
	localparam logic [7:0] AXI_CTRL = 8'h00;
	localparam logic [7:0] AXI_STATUS = 8'h04;
	localparam logic [7:0] AXI_STRAP = 8'h08;
	localparam int CTRL_GO_BIT = 31;
	localparam int CTRL_WRITE_BIT = 16;
	localparam logic [31:0] STRAP_RESET = 32'h0000_0022;
	localparam logic [1:0] RESP_OKAY = 2'h0;

	// three-flop filter: a bit changes only once stages two and three agree
	function automatic logic [31:0] hbp_filter(input logic [31:0] held,
		input logic [31:0] st2, input logic [31:0] st3);
		hbp_filter = (st2 & st3) | (held & (st2 ^ st3));
	endfunction : hbp_filter

endpackage : hbp_pkg

// ### hbp_if.sv
// hbp_if: pins between the host controller and the device port
`timescale 1ns/1ps
`default_nettype none
interface hbp_if;
	// ==========================================================
	// host-driven pins and straps
	logic [2:0] host_type_strap;
	logic primary_backup_strap;
	logic network_rate_strap;
	logic power_on_reset_n;
	logic write_strobe_n;
	logic read_strobe_n;
	logic ale;
	logic [6:0] h_addr_o;
	logic [6:0] h_addr_oe_n;
	logic h_sel_o;
	logic h_sel_oe_n;
	logic [7:0] h_ad_o;
	logic [7:0] h_ad_oe_n;
	// ==========================================================
	// device-driven pins
	logic ready;
	logic [6:0] d_addr_o;
	logic [6:0] d_addr_oe_n;
	logic d_sel_o;
	logic d_sel_oe_n;
	logic [7:0] d_ad_o;
	logic [7:0] d_ad_oe_n;
	// ==========================================================
	// wire levels: address and data pulled low, select pulled high
	logic [6:0] addr;
	logic select_n;
	logic [7:0] ad;
	assign addr = (~d_addr_oe_n & d_addr_o) | (~h_addr_oe_n & h_addr_o);
	assign select_n = ~((~d_sel_oe_n & ~d_sel_o) | (~h_sel_oe_n & ~h_sel_o));
	assign ad = (~d_ad_oe_n & d_ad_o) | (~h_ad_oe_n & h_ad_o);

	modport device (
		input host_type_strap, primary_backup_strap, network_rate_strap,
		input power_on_reset_n, write_strobe_n, read_strobe_n, ale,
		input addr, select_n, ad,
		output ready, d_addr_o, d_addr_oe_n, d_sel_o, d_sel_oe_n,
		output d_ad_o, d_ad_oe_n
	);
	modport host (
		output host_type_strap, primary_backup_strap, network_rate_strap,
		output power_on_reset_n, write_strobe_n, read_strobe_n, ale,
		output h_addr_o, h_addr_oe_n, h_sel_o, h_sel_oe_n, h_ad_o, h_ad_oe_n,
		input ready, addr, select_n, ad
	);
endinterface : hbp_if
`default_nettype wire

// ### hbp_device_end.sv
// hbp_device_end: register port of the timing device, with reset and straps
`timescale 1ns/1ps
`default_nettype none
module hbp_device_end #(
	parameter int EPROM_WAIT = hbp_pkg::EPROM_WAIT_CYC
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// pins to the host
	hbp_if.device bus,
	// register values, bus style and loader status seen by the rest of the device
	output logic [hbp_pkg::DATA_W-1:0] operating_mode,
	output logic [hbp_pkg::DATA_W-1:0] rate_family,
	output hbp_pkg::hbp_style_t bus_style,
	output logic eprom_busy
);
	import hbp_pkg::*;

	// ==========================================================
	// pin synchronisers
	localparam int NIN = 25;
	logic [NIN-1:0] raw;
	logic [NIN-1:0] s1, s2, s3, f, fq;
	logic [31:0] filt;
	assign raw = {bus.host_type_strap, bus.primary_backup_strap,
		bus.network_rate_strap, bus.power_on_reset_n, bus.write_strobe_n,
		bus.read_strobe_n, bus.ale, bus.select_n, bus.addr, bus.ad};
	assign filt = hbp_filter({7'h00, f}, {7'h00, s2}, {7'h00, s3});

	// no reset here, so straps settle while reset is still held
	always_ff @(posedge aclk) begin
		s1 <= raw;
		s2 <= s1;
		s3 <= s2;
		f <= filt[NIN-1:0];
		fq <= f;
	end

	logic [2:0] p_type;
	logic p_pb, p_net, p_por_n, p_wr_n, p_rd_n, p_ale, p_sel_n;
	logic [ADDR_W-1:0] p_addr;
	logic [DATA_W-1:0] p_ad;
	assign {p_type, p_pb, p_net, p_por_n, p_wr_n, p_rd_n, p_ale, p_sel_n,
		p_addr, p_ad} = f;

	logic rst;
	logic ale_fall, sclk_rise, sclk_fall;
	assign rst = !aresetn || !p_por_n;
	assign ale_fall = fq[16] && !p_ale;
	assign sclk_rise = !fq[16] && p_ale;
	assign sclk_fall = ale_fall;

	// ==========================================================
	// bus style and access decode
	hbp_style_t style;
	always_ff @(posedge aclk) begin
		if (rst) begin
			style <= hbp_style_t'(p_type);
		end
	end
	assign bus_style = style;

	logic [ADDR_W-1:0] addr_latch;
	always_ff @(posedge aclk) begin
		if (rst) begin
			addr_latch <= '0;
		end else if (ale_fall && style == STYLE_MUX) begin
			addr_latch <= p_ad[ADDR_W-1:0];
		end else if (ale_fall) begin
			addr_latch <= p_addr;
		end
	end

	logic rd_act, wr_act;
	logic [ADDR_W-1:0] cur_addr;
	always_comb begin
		if (style == STYLE_DIR) begin
			rd_act = !p_sel_n && !p_rd_n && p_wr_n;
			wr_act = !p_sel_n && !p_rd_n && !p_wr_n;
		end else begin
			rd_act = !p_sel_n && !p_rd_n;
			wr_act = !p_sel_n && !p_wr_n;
		end
		// multiplexed bus keeps the latched address, the others use pins
		cur_addr = (style == STYLE_MUX) ? addr_latch : p_addr;
	end

	// ==========================================================
	// access sequencer
	typedef enum logic [5:0] {
		ST_IDLE = 6'b00_0001,
		ST_READ = 6'b00_0010,
		ST_WRITE = 6'b00_0100,
		ST_SERIAL = 6'b00_1000,
		ST_EPROM = 6'b01_0000,
		ST_HALT = 6'b10_0000
	} hbp_dev_state_t;
	hbp_dev_state_t state;

	logic [DATA_W-1:0] mem [0:NREGS-1];
	logic [ADDR_W-1:0] waddr;
	logic [SER_CNT_W-1:0] bitcnt;
	logic [DATA_W-1:0] ser_cmd, ser_wsh, ser_rsh;
	logic [ADDR_W-1:0] eaddr;
	logic [7:0] ewait;
	logic we_par, we_ser, we_ep;
	logic ser_read;

	assign ser_read = ser_cmd[DATA_W-1];
	assign we_par = (state == ST_WRITE) && !wr_act;
	assign we_ser = (state == ST_SERIAL) && sclk_rise && !ser_read &&
		bitcnt == SER_CNT_W'(SER_FRAME_BITS - 1);
	assign we_ep = (state == ST_EPROM) && ewait == 8'(EPROM_WAIT);

	always_ff @(posedge aclk) begin
		if (rst) begin
			state <= ST_IDLE;
			bus.ready <= 1'b0;
			waddr <= '0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (style == STYLE_EPROM) begin
						state <= ST_EPROM;
					end else if (style == STYLE_SERIAL && !p_sel_n) begin
						state <= ST_SERIAL;
					end else if (style != STYLE_SERIAL && rd_act) begin
						state <= ST_READ;
						bus.ready <= 1'b1;
					end else if (style != STYLE_SERIAL && wr_act) begin
						state <= ST_WRITE;
						waddr <= cur_addr;
						bus.ready <= 1'b1;
					end
				end
				ST_READ: begin
					if (!rd_act) begin
						state <= ST_IDLE;
						bus.ready <= 1'b0;
					end
				end
				ST_WRITE: begin
					if (!wr_act) begin
						state <= ST_IDLE;
						bus.ready <= 1'b0;
					end
				end
				ST_SERIAL: begin
					if (p_sel_n) begin
						state <= ST_IDLE;
						bus.ready <= 1'b0;
					end else if (sclk_rise &&
						bitcnt == SER_CNT_W'(SER_FRAME_BITS - 1)) begin
						bus.ready <= 1'b1;
					end
				end
				ST_EPROM: begin
					if (we_ep && eaddr == ADDR_W'(NREGS - 1)) begin
						state <= ST_HALT;
					end
				end
				ST_HALT: begin
					state <= ST_HALT;
				end
			endcase
		end
	end

	// ==========================================================
	// serial shifter: direction bit, address, then data, msb first
	always_ff @(posedge aclk) begin
		if (rst || state != ST_SERIAL) begin
			bitcnt <= '0;
			ser_cmd <= '0;
			ser_wsh <= '0;
			ser_rsh <= '0;
		end else if (sclk_rise) begin
			bitcnt <= bitcnt + 1'b1;
			if (bitcnt < SER_CNT_W'(SER_CMD_BITS)) begin
				ser_cmd <= {ser_cmd[DATA_W-2:0], p_addr[0]};
			end else begin
				ser_wsh <= {ser_wsh[DATA_W-2:0], p_addr[0]};
			end
		end else if (sclk_fall && ser_read &&
			bitcnt == SER_CNT_W'(SER_CMD_BITS)) begin
			ser_rsh <= mem[ser_cmd[ADDR_W-1:0]] << 1;
		end else if (sclk_fall) begin
			ser_rsh <= ser_rsh << 1;
		end
	end

	// ==========================================================
	// data bus drive
	always_ff @(posedge aclk) begin
		if (rst) begin
			bus.d_ad_o <= '0;
			bus.d_ad_oe_n <= '1;
		end else if (state == ST_IDLE && style != STYLE_SERIAL &&
			style != STYLE_EPROM && rd_act) begin
			bus.d_ad_o <= mem[cur_addr];
			bus.d_ad_oe_n <= '0;
		end else if (state == ST_READ && rd_act) begin
			bus.d_ad_oe_n <= '0;
		end else if (state == ST_SERIAL && !p_sel_n) begin
			if (sclk_fall && ser_read &&
				bitcnt == SER_CNT_W'(SER_CMD_BITS)) begin
				bus.d_ad_o[0] <= mem[ser_cmd[ADDR_W-1:0]][DATA_W-1];
				bus.d_ad_oe_n[0] <= 1'b0;
			end else if (sclk_fall && bitcnt > SER_CNT_W'(SER_CMD_BITS) &&
				bitcnt < SER_CNT_W'(SER_FRAME_BITS) && ser_read) begin
				bus.d_ad_o[0] <= ser_rsh[DATA_W-1];
			end
		end else begin
			bus.d_ad_oe_n <= '1;
		end
	end

	// ==========================================================
	// eprom loader: walks every address once after reset
	always_ff @(posedge aclk) begin
		if (rst) begin
			eaddr <= '0;
			ewait <= '0;
			bus.d_addr_o <= '0;
			bus.d_addr_oe_n <= '1;
			bus.d_sel_o <= 1'b1;
			bus.d_sel_oe_n <= 1'b1;
			eprom_busy <= 1'b0;
		end else if (state == ST_EPROM) begin
			bus.d_addr_oe_n <= '0;
			bus.d_sel_oe_n <= 1'b0;
			bus.d_sel_o <= 1'b0;
			bus.d_addr_o <= eaddr;
			eprom_busy <= 1'b1;
			if (we_ep) begin
				ewait <= '0;
				eaddr <= eaddr + 1'b1;
			end else begin
				ewait <= ewait + 1'b1;
			end
		end else begin
			bus.d_sel_o <= 1'b1;
			eprom_busy <= 1'b0;
		end
	end

	// ==========================================================
	// register file
	always_ff @(posedge aclk) begin
		if (rst) begin
			for (int i = 0; i < NREGS; i++) begin
				mem[i] <= REG_RESET;
			end
			mem[REG_OPMODE][OPMODE_PB_BIT] <= p_pb;
			mem[REG_OPMODE][OPMODE_NET_BIT] <= p_net;
			// a low strap leaves zeros: the 2.048 MHz family
			mem[REG_RATE][RATE_NET_LO_BIT] <= p_net;
			mem[REG_RATE][RATE_NET_HI_BIT] <= p_net;
		end else if (we_par) begin
			mem[waddr] <= p_ad;
		end else if (we_ser) begin
			mem[ser_cmd[ADDR_W-1:0]] <= {ser_wsh[DATA_W-2:0], p_addr[0]};
		end else if (we_ep) begin
			mem[eaddr] <= p_ad;
		end
	end

	assign operating_mode = mem[REG_OPMODE];
	assign rate_family = mem[REG_RATE];
endmodule : hbp_device_end
`default_nettype wire

// ### hbp_host_end.sv
// hbp_host_end: bus controller that drives the device pins from AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module hbp_host_end (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// external memory served in eprom style
	output logic [hbp_pkg::ADDR_W-1:0] eprom_addr,
	input wire logic [hbp_pkg::DATA_W-1:0] eprom_data,
	// pins to the device
	hbp_if.host bus
);
	import hbp_pkg::*;

	// ==========================================================
	// pin synchronisers
	logic [16:0] s1, s2, s3, f;
	logic [31:0] filt;
	assign filt = hbp_filter({15'h0000, f}, {15'h0000, s2}, {15'h0000, s3});
	always_ff @(posedge aclk) begin
		s1 <= {bus.ready, bus.select_n, bus.addr, bus.ad};
		s2 <= s1;
		s3 <= s2;
		f <= filt[16:0];
	end
	logic p_ready, p_sel_n;
	logic [ADDR_W-1:0] p_addr;
	logic [DATA_W-1:0] p_ad;
	assign {p_ready, p_sel_n, p_addr, p_ad} = f;

	// ==========================================================
	// AXI4-Lite registers
	logic [31:0] ctrl, strap;
	logic busy, go;
	logic [DATA_W-1:0] rdata;
	hbp_style_t style;
	assign style = hbp_style_t'(strap[2:0]);
	assign go = s_axi_awready && s_axi_awaddr == AXI_CTRL &&
		s_axi_wdata[CTRL_GO_BIT] && !busy;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			ctrl <= '0;
			strap <= STRAP_RESET;
		end else begin
			// address and data are taken together, one write at a time
			s_axi_awready <= s_axi_awvalid && s_axi_wvalid &&
				!s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= s_axi_awvalid && s_axi_wvalid &&
				!s_axi_awready && !s_axi_bvalid;
			if (s_axi_awready) begin
				s_axi_bvalid <= 1'b1;
				if (go) begin
					ctrl <= s_axi_wdata;
				end
				if (s_axi_awaddr == AXI_STRAP && s_axi_wstrb[0]) begin
					strap[7:0] <= s_axi_wdata[7:0];
				end
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	assign s_axi_bresp = RESP_OKAY;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				unique case (s_axi_araddr)
					AXI_CTRL: s_axi_rdata <= ctrl;
					AXI_STATUS: s_axi_rdata <= {16'h0000, rdata, 7'h00, busy};
					AXI_STRAP: s_axi_rdata <= strap;
					default: s_axi_rdata <= '0;
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
	assign s_axi_rresp = RESP_OKAY;

	// straps and power-on reset follow the strap register
	assign bus.host_type_strap = strap[2:0];
	assign bus.primary_backup_strap = strap[3];
	assign bus.network_rate_strap = strap[4];
	assign bus.power_on_reset_n = strap[5];

	// ==========================================================
	// cycle sequencer
	typedef enum logic [5:0] {
		H_IDLE = 6'b00_0001,
		H_ALE = 6'b00_0010,
		H_LAT = 6'b00_0100,
		H_STRB = 6'b00_1000,
		H_REL = 6'b01_0000,
		H_SER = 6'b10_0000
	} hbp_host_state_t;
	hbp_host_state_t state;
	logic [7:0] cnt;
	logic [SER_CNT_W:0] ph;
	logic [SER_FRAME_BITS-1:0] shreg;
	logic is_wr;
	assign is_wr = ctrl[CTRL_WRITE_BIT];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= H_IDLE;
			busy <= 1'b0;
			rdata <= '0;
			cnt <= '0;
			ph <= '0;
			shreg <= '0;
			bus.write_strobe_n <= 1'b1;
			bus.read_strobe_n <= 1'b1;
			bus.ale <= 1'b0;
			bus.h_addr_o <= '0;
			bus.h_addr_oe_n <= '1;
			bus.h_sel_o <= 1'b1;
			bus.h_sel_oe_n <= 1'b1;
			bus.h_ad_o <= '0;
			bus.h_ad_oe_n <= '1;
			eprom_addr <= '0;
		end else begin
			cnt <= cnt + 1'b1;
			unique case (state)
				H_IDLE: begin
					cnt <= '0;
					if (style == STYLE_EPROM) begin
						bus.h_addr_oe_n <= '1;
						bus.h_sel_oe_n <= 1'b1;
						eprom_addr <= p_addr;
						bus.h_ad_o <= eprom_data;
						bus.h_ad_oe_n <= p_sel_n ? 8'hFF : 8'h00;
					end else begin
						bus.h_addr_oe_n <= '0;
						bus.h_sel_oe_n <= 1'b0;
						bus.h_ad_oe_n <= '1;
					end
					if (go && style != STYLE_EPROM) begin
						busy <= 1'b1;
						state <= H_LAT;
					end
					if (go && style == STYLE_SERIAL) begin
						bus.h_sel_o <= 1'b0;
						shreg <= {!s_axi_wdata[CTRL_WRITE_BIT],
							s_axi_wdata[6:0], s_axi_wdata[15:8]};
						bus.h_addr_o[0] <= !s_axi_wdata[CTRL_WRITE_BIT];
						ph <= '0;
						state <= H_SER;
					end else if (go && style == STYLE_MUX) begin
						bus.h_sel_o <= 1'b0;
						bus.h_ad_o <= {1'b0, s_axi_wdata[6:0]};
						bus.h_ad_oe_n <= '0;
						bus.ale <= 1'b1;
						state <= H_ALE;
					end else if (go) begin
						bus.h_sel_o <= 1'b0;
						bus.h_addr_o <= s_axi_wdata[6:0];
						bus.h_ad_o <= s_axi_wdata[15:8];
						bus.h_ad_oe_n <= s_axi_wdata[CTRL_WRITE_BIT] ? 8'h00 : 8'hFF;
					end
				end
				H_ALE: begin
					if (cnt == 8'(HOST_HOLD_CYC)) begin
						bus.ale <= 1'b0;
						cnt <= '0;
						state <= H_LAT;
					end
				end
				H_LAT: begin
					if (cnt == 8'(HOST_HOLD_CYC)) begin
						bus.h_ad_o <= ctrl[15:8];
						bus.h_ad_oe_n <= is_wr ? 8'h00 : 8'hFF;
						if (style == STYLE_DIR) begin
							bus.write_strobe_n <= !is_wr;
							bus.read_strobe_n <= 1'b0;
						end else begin
							bus.write_strobe_n <= !is_wr;
							bus.read_strobe_n <= is_wr;
						end
						state <= H_STRB;
					end
				end
				H_STRB: begin
					if (p_ready) begin
						if (style != STYLE_SERIAL && !is_wr) begin
							rdata <= p_ad;
						end
						bus.write_strobe_n <= 1'b1;
						bus.read_strobe_n <= 1'b1;
						bus.h_sel_o <= 1'b1;
						state <= H_REL;
					end
				end
				H_REL: begin
					if (!p_ready) begin
						bus.h_ad_oe_n <= '1;
						busy <= 1'b0;
						state <= H_IDLE;
					end
				end
				H_SER: begin
					if (cnt == 8'(SCLK_HALF_CYC - 1)) begin
						cnt <= '0;
						ph <= ph + 1'b1;
						if (!ph[0]) begin
							bus.ale <= 1'b1;
						end else begin
							// sample a whole period after the device shifted:
							// both sync paths together outlast one half period
							if (ph > (SER_CNT_W + 1)'(SER_FRAME_BITS)) begin
								rdata <= {rdata[6:0], p_ad[0]};
							end
							bus.ale <= 1'b0;
							shreg <= shreg << 1;
							bus.h_addr_o[0] <= shreg[SER_FRAME_BITS-2];
							if (ph == (SER_CNT_W + 1)'(2 * SER_FRAME_BITS - 1)) begin
								state <= H_STRB;
							end
						end
					end
				end
			endcase
		end
	end
endmodule : hbp_host_end
`default_nettype wire

// ### hbp_properties.sv
// hbp_properties: pin link checks between the two ends
`timescale 1ns/1ps
`default_nettype none
module hbp_properties (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// pins between the ends
	input wire logic power_on_reset_n,
	input wire logic read_strobe_n,
	input wire logic select_n,
	input wire logic ready,
	input wire logic [7:0] d_ad_o,
	input wire logic [7:0] d_ad_oe_n,
	input wire logic [6:0] d_addr_oe_n,
	input wire logic d_sel_oe_n
);
	default clocking dc @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ==========================================================
	// access steps
	sequence s_read_start;
		$fell(read_strobe_n) && !select_n;
	endsequence
	sequence s_ack;
		##[1:12] ready;
	endsequence
	// ==========================================================
	// pin assertions
	a_reset_quiet: assert property ($rose(aresetn) |-> !ready &&
		&d_ad_oe_n && &d_addr_oe_n && d_sel_oe_n)
		else $error("pins driven after reset");
	a_por_quiet: assert property (!power_on_reset_n [*6] |->
		!ready && &d_ad_oe_n) else $error("busy during power-on reset");
	a_read_ack: assert property (s_read_start |-> s_ack)
		else $error("no ready after read strobe");
	a_ready_stands: assert property ($rose(ready) |=> ready [*2])
		else $error("ready too short");
	a_data_stable: assert property (ready && $past(ready) &&
		$stable(d_ad_oe_n) && !(&d_ad_oe_n) |-> $stable(d_ad_o))
		else $error("read data moved under ready");
	a_drive_on_read: assert property ($fell(&d_ad_oe_n) |->
		!select_n && (!read_strobe_n || &d_ad_oe_n[7:1]))
		else $error("bus driven outside read");
	a_ready_release: assert property ($rose(select_n) |->
		##[1:12] !ready) else $error("ready kept after deselect");
	a_sel_ignored: assert property (select_n [*8] |-> !ready)
		else $error("ready while deselected");
endmodule : hbp_properties
`default_nettype wire

// ### test_host_bus_port_and_straps.sv
// test_host_bus_port_and_straps: both ends driven over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module test_host_bus_port_and_straps;
	import hbp_pkg::*;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr, opmode, ratefam;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	hbp_style_t style;
	logic [6:0] eaddr_tb;
	logic ebusy;
	int fail_count = 0;
	int cmp_count = 0;
	int cycles = 0;
	hbp_if hif();
	hbp_device_end u_hbp_device_end (.aclk(aclk), .aresetn(aresetn),
		.bus(hif), .operating_mode(opmode), .rate_family(ratefam),
		.bus_style(style), .eprom_busy(ebusy));
	hbp_host_end u_hbp_host_end (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .eprom_addr(eaddr_tb),
		.eprom_data({1'b0, eaddr_tb} ^ 8'h3C), .bus(hif));
	hbp_properties u_hbp_properties (.aclk(aclk), .aresetn(aresetn),
		.power_on_reset_n(hif.power_on_reset_n),
		.read_strobe_n(hif.read_strobe_n), .select_n(hif.select_n),
		.ready(hif.ready), .d_ad_o(hif.d_ad_o), .d_ad_oe_n(hif.d_ad_oe_n),
		.d_addr_oe_n(hif.d_addr_oe_n), .d_sel_oe_n(hif.d_sel_oe_n));
	// ==========================================================
	// shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok, w_ok;
		aw_ok = 0;
		w_ok = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (awready) begin
				aw_ok = 1;
				awvalid <= 0;
			end
			if (wready) begin
				w_ok = 1;
				wvalid <= 0;
			end
		end
		while (!bvalid) @(posedge aclk);
		bready <= 0;
		@(posedge aclk);
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge aclk); while (!arready);
		arvalid <= 0;
		while (!rvalid) @(posedge aclk);
		d = rdata;
		rready <= 0;
		@(posedge aclk);
	endtask : axi_rd
	// one register access on the pins, waits for busy to clear
	task automatic pin_op(input logic [6:0] a, input logic w,
		input logic [7:0] d, output logic [31:0] s);
		axi_wr(AXI_CTRL, {1'b1, 14'h0, w, d, 1'b0, a});
		s = 1;
		for (int i = 0; i < 300 && s[0] === 1'b1; i++) axi_rd(AXI_STATUS, s);
		chk(s[0], 0);
	endtask : pin_op
	// straps are only captured while power-on reset or aresetn is low
	task automatic por(input logic [4:0] st);
		axi_wr(AXI_STRAP, {27'h0, st});
		repeat (10) @(posedge aclk);
		axi_wr(AXI_STRAP, {26'h0, 1'b1, st});
		repeat (20) @(posedge aclk);
	endtask : por
	// ==========================================================
	// scenarios
	task automatic t_axi();
		logic [31:0] s;
		axi_rd(AXI_STRAP, s);
		chk(s, STRAP_RESET);
		axi_wr(8'h0C, 32'hFFFF_FFFF);
		axi_rd(8'h0C, s);
		chk(s, 0);
		$display("test axi done");
	endtask : t_axi
	task automatic t_straps();
		logic [31:0] s;
		logic b;
		for (int i = 0; i < 2; i++) begin
			b = i[0];
			pin_op(REG_OPMODE, 1, 8'hFF, s);
			por({b, b, STYLE_SEP});
			chk(style, STYLE_SEP);
			chk(opmode, {5'h0, b, b, 1'b0});
			chk(ratefam, {1'b0, b, b, 5'h0});
			pin_op(REG_OPMODE, 0, 8'h00, s);
			chk(s[15:8], {5'h0, b, b, 1'b0});
		end
		$display("test straps done");
	endtask : t_straps
	task automatic t_styles();
		logic [31:0] s;
		hbp_style_t st[3] = '{STYLE_MUX, STYLE_SEP, STYLE_DIR};
		foreach (st[i]) begin
			por({2'b0, st[i]});
			chk(style, st[i]);
			pin_op(REG_RATE, 1, 8'h5A ^ i[7:0], s);
			chk(ratefam, 8'h5A ^ i[7:0]);
			pin_op(REG_RATE, 0, 8'h00, s);
			chk(s[15:8], 8'h5A ^ i[7:0]);
			pin_op(7'h7F, 0, 8'h00, s);
			chk(s[15:8], REG_RESET);
		end
		$display("test styles done");
	endtask : t_styles
	task automatic t_serial();
		logic [31:0] s;
		por({2'b0, STYLE_SERIAL});
		chk(style, STYLE_SERIAL);
		pin_op(REG_RATE, 1, 8'hA5, s);
		chk(ratefam, 8'hA5);
		pin_op(REG_RATE, 0, 8'h00, s);
		chk(s[15:8], 8'hA5);
		$display("test serial done");
	endtask : t_serial
	// memory image is address xor 0x3c; the loader halts after one pass
	task automatic t_eprom();
		por({2'b0, STYLE_EPROM});
		repeat (200) @(posedge aclk);
		chk(ebusy, 1);
		chk(hif.d_sel_oe_n, 0);
		chk(hif.d_addr_oe_n, 0);
		repeat (2000) @(posedge aclk);
		chk(ebusy, 0);
		chk(opmode, {1'b0, REG_OPMODE} ^ 8'h3C);
		chk(ratefam, {1'b0, REG_RATE} ^ 8'h3C);
		$display("test eprom done");
	endtask : t_eprom
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up
	// ==========================================================
	// clock, reset, sequence and hang guard
	initial begin
		aclk = 0;
		forever #50 aclk = ~aclk;
	end
	initial begin
		aresetn = 0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, araddr, wdata} = 48'h0;
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		repeat (20) @(posedge aclk);
		t_axi();
		t_straps();
		t_styles();
		t_serial();
		t_eprom();
		wrap_up();
	end
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			fail_count++;
			wrap_up();
		end
	end
endmodule : test_host_bus_port_and_straps
`default_nettype wire
